//--- shared/pfrm_pkg.sv
package pfrm_pkg;
    // ========================================================
    // Timing
    // ========================================================
    localparam int CLK_PERIOD_NS = 4;
    // Overvoltage filter, leading-edge blanking, brown-out deglitch
    localparam int OV_FILT_TIME_NS = 1000;
    localparam int LEB_TIME_NS = 200;
    localparam int BO_DEGLITCH_TIME_NS = 50000000;
    // Least times round up to whole cycles
    localparam int OV_FILT_CYC =
        (OV_FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LEB_CYC = (LEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BO_DEGLITCH_CYC =
        (BO_DEGLITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Supply cycles of one hiccup
    localparam int RESTART_CYCLES = 6;
    localparam int CNT_W = 24;
    localparam int RST_CNT_W = 3;

    // ========================================================
    // Types
    // ========================================================
    typedef enum logic [2:0] {
        ST_WAIT_BROWN_IN,
        ST_SOFT_START,
        ST_RUN,
        ST_FAULT_AUTO,
        ST_FAULT_LATCH,
        ST_COND_WAIT,
        ST_COND_CYCLE
    } pfrm_state_e;

    // Digitised comparator and fault-cause levels from the pins
    typedef struct packed {
        logic supply_above_off;  // primary_supply above off level
        logic supply_at_on;      // primary_supply reached on level
        logic soft_start_end;    // soft_start_end_level reached
        logic secondary_active;  // activity seen from secondary
        logic ov_voltage;        // overvoltage_voltage_threshold cmp
        logic ov_current;        // overvoltage_current_threshold cmp
        logic high_side_on;      // high_side_switch conducting
        logic above_brown_in;    // above brown_in_peak_level
        logic below_brown_out;   // below brown_out_peak_level
        logic over_clamp;        // above peak_current_clamp_level
        logic xcap_discharge;    // input capacitor discharge fault
        logic auto_cause;        // other auto-restart fault cause
        logic cond_cause;        // conditioned-restart fault cause
        logic latch_cause;       // latched fault cause
    } pfrm_cmp_s;
endpackage

//--- core/pfrm_fault_manager.sv
`timescale 1ns/1ps
module pfrm_fault_manager #(
    parameter int BO_DG_CYC = pfrm_pkg::BO_DEGLITCH_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire pfrm_pkg::pfrm_cmp_s cmp_i,
    input wire logic low_side_req_i,
    output logic switching_en_o,
    output logic low_side_gate_cmd_o,
    output logic hv_startup_en_o,
    output logic fault_auto_o,
    output logic fault_latched_o,
    output logic fault_cond_o
);
    // ========================================================
    // Pin synchronisers
    // ========================================================
    pfrm_pkg::pfrm_cmp_s sync1_r;
    pfrm_pkg::pfrm_cmp_s cmp_r;

    // Every comparator level crosses two flops before use
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_r <= '0;
            cmp_r <= '0;
        end else begin
            sync1_r <= cmp_i;
            cmp_r <= sync1_r;
        end
    end

    // ========================================================
    // Sequencer state
    // ========================================================
    pfrm_pkg::pfrm_state_e state_r, state_nxt;
    logic [pfrm_pkg::RST_CNT_W-1:0] rst_cnt_r, rst_cnt_nxt;
    logic [pfrm_pkg::CNT_W-1:0] ov_cnt_r, ov_cnt_nxt;
    logic [pfrm_pkg::CNT_W-1:0] bo_cnt_r, bo_cnt_nxt;
    logic [pfrm_pkg::CNT_W-1:0] leb_cnt_r, leb_cnt_nxt;
    logic armed_r, armed_nxt;
    logic on_prev_r, on_prev_nxt;
    logic hv_r, hv_nxt;
    logic lon_r, lon_nxt;
    logic cut_r, cut_nxt;
    logic cycle_evt, ov_act, ov_trip, bo_trip, mains_lost;
    logic sw_on, in_fault, ssto, uvlo;

    // Saturating increment shared by all interval counters
    function automatic logic [pfrm_pkg::CNT_W-1:0] sat_inc(
        input logic [pfrm_pkg::CNT_W-1:0] v,
        input logic [pfrm_pkg::CNT_W-1:0] lim);
        sat_inc = (v >= lim) ? lim : v + 1'b1;
    endfunction

    localparam logic [pfrm_pkg::CNT_W-1:0] OV_LIM =
        pfrm_pkg::CNT_W'(pfrm_pkg::OV_FILT_CYC);
    localparam logic [pfrm_pkg::CNT_W-1:0] BO_LIM =
        pfrm_pkg::CNT_W'(BO_DG_CYC);
    localparam logic [pfrm_pkg::CNT_W-1:0] LEB_LIM =
        pfrm_pkg::CNT_W'(pfrm_pkg::LEB_CYC);
    localparam logic [pfrm_pkg::RST_CNT_W-1:0] RST_LAST =
        pfrm_pkg::RST_CNT_W'(pfrm_pkg::RESTART_CYCLES - 1);

    // Next-state logic for the whole sequencer
    always_comb begin
        state_nxt = state_r;
        rst_cnt_nxt = rst_cnt_r;
        on_prev_nxt = cmp_r.supply_at_on;
        sw_on = (state_r == pfrm_pkg::ST_SOFT_START) ||
                (state_r == pfrm_pkg::ST_RUN);
        in_fault = !sw_on && (state_r != pfrm_pkg::ST_WAIT_BROWN_IN);
        // A supply cycle is a fall below off, then a rise to on
        cycle_evt = armed_r && cmp_r.supply_at_on && !on_prev_r;
        armed_nxt = armed_r;
        if (!cmp_r.supply_above_off) begin
            armed_nxt = 1'b1;
        end else if (cycle_evt) begin
            armed_nxt = 1'b0;
        end
        // startup pulsing
        // Startup generator recharges from off level up to on level
        hv_nxt = 1'b0;
        if (in_fault) begin
            if (!cmp_r.supply_above_off) begin
                hv_nxt = 1'b1;
            end else if (cmp_r.supply_at_on) begin
                hv_nxt = 1'b0;
            end else begin
                hv_nxt = hv_r;
            end
        end
        // voltage or current threshold
        // Either winding style may trip; sampled in high-side on-time
        ov_act = (state_r == pfrm_pkg::ST_SOFT_START) &&
                 cmp_r.high_side_on &&
                 (cmp_r.ov_voltage || cmp_r.ov_current);
        ov_cnt_nxt = ov_act ? sat_inc(ov_cnt_r, OV_LIM) : '0;
        ov_trip = ov_act && (ov_cnt_r == OV_LIM);
        bo_cnt_nxt = cmp_r.below_brown_out ? sat_inc(bo_cnt_r, BO_LIM) : '0;
        bo_trip = cmp_r.below_brown_out && (bo_cnt_r == BO_LIM);
        mains_lost = bo_trip || cmp_r.xcap_discharge;
        ssto = cmp_r.soft_start_end && !cmp_r.secondary_active;
        uvlo = !cmp_r.supply_above_off;
        unique case (state_r)
            pfrm_pkg::ST_WAIT_BROWN_IN: begin
                rst_cnt_nxt = '0;
                if (cmp_r.above_brown_in) begin
                    state_nxt = pfrm_pkg::ST_SOFT_START;
                end
            end
            pfrm_pkg::ST_SOFT_START, pfrm_pkg::ST_RUN: begin
                rst_cnt_nxt = '0;
                if (cmp_r.latch_cause) begin
                    state_nxt = pfrm_pkg::ST_FAULT_LATCH;
                end else if (cmp_r.cond_cause) begin
                    state_nxt = pfrm_pkg::ST_COND_WAIT;
                end else if (cmp_r.auto_cause || uvlo ||
                             (state_r == pfrm_pkg::ST_SOFT_START &&
                              (ov_trip || ssto))) begin
                    state_nxt = pfrm_pkg::ST_FAULT_AUTO;
                end else if (state_r == pfrm_pkg::ST_SOFT_START &&
                             cmp_r.secondary_active) begin
                    // Secondary now owns conversion; OV check retires
                    state_nxt = pfrm_pkg::ST_RUN;
                end
            end
            pfrm_pkg::ST_FAULT_AUTO: begin
                if (cycle_evt) begin
                    if (rst_cnt_r == RST_LAST) begin
                        state_nxt = pfrm_pkg::ST_SOFT_START;
                        rst_cnt_nxt = '0;
                    end else begin
                        rst_cnt_nxt = rst_cnt_r + 1'b1;
                    end
                end
            end
            pfrm_pkg::ST_FAULT_LATCH: begin
                state_nxt = pfrm_pkg::ST_FAULT_LATCH;
            end
            pfrm_pkg::ST_COND_WAIT: begin
                // wait cause gone, then demand a fresh fall
                if (!cmp_r.cond_cause) begin
                    state_nxt = pfrm_pkg::ST_COND_CYCLE;
                    armed_nxt = !cmp_r.supply_above_off;
                end
            end
            pfrm_pkg::ST_COND_CYCLE: begin
                if (cmp_r.cond_cause) begin
                    state_nxt = pfrm_pkg::ST_COND_WAIT;
                end else if (cycle_evt) begin
                    state_nxt = pfrm_pkg::ST_SOFT_START;
                end
            end
            default: begin
                state_nxt = pfrm_pkg::ST_WAIT_BROWN_IN;
            end
        endcase
        // mains loss clears every stored fault
        if (mains_lost) begin
            state_nxt = pfrm_pkg::ST_WAIT_BROWN_IN;
            rst_cnt_nxt = '0;
        end
        leb_cnt_nxt = low_side_req_i ? sat_inc(leb_cnt_r, LEB_LIM) : '0;
        cut_nxt = low_side_req_i &&
                  (cut_r || (leb_cnt_r == LEB_LIM && cmp_r.over_clamp));
        lon_nxt = sw_on && low_side_req_i && !cut_nxt;
    end

    // Registers only
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= pfrm_pkg::ST_WAIT_BROWN_IN;
            rst_cnt_r <= '0;
            ov_cnt_r <= '0;
            bo_cnt_r <= '0;
            leb_cnt_r <= '0;
            armed_r <= 1'b0;
            on_prev_r <= 1'b0;
            hv_r <= 1'b0;
            lon_r <= 1'b0;
            cut_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            ov_cnt_r <= ov_cnt_nxt;
            bo_cnt_r <= bo_cnt_nxt;
            leb_cnt_r <= leb_cnt_nxt;
            armed_r <= armed_nxt;
            on_prev_r <= on_prev_nxt;
            hv_r <= hv_nxt;
            lon_r <= lon_nxt;
            cut_r <= cut_nxt;
        end
    end

    // Status outputs straight from the state register; gate and startup commands from lon_r and hv_r
    assign switching_en_o = (state_r == pfrm_pkg::ST_SOFT_START) ||
                            (state_r == pfrm_pkg::ST_RUN);
    assign low_side_gate_cmd_o = lon_r;
    assign hv_startup_en_o = hv_r;
    assign fault_auto_o = (state_r == pfrm_pkg::ST_FAULT_AUTO);
    assign fault_latched_o = (state_r == pfrm_pkg::ST_FAULT_LATCH);
    assign fault_cond_o = (state_r == pfrm_pkg::ST_COND_WAIT) ||
                          (state_r == pfrm_pkg::ST_COND_CYCLE);

    // ========================================================
    // Assertions
    // ========================================================
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_last_hiccup;
        state_r == pfrm_pkg::ST_FAULT_AUTO && cycle_evt &&
        rst_cnt_r == RST_LAST && !mains_lost;
    endsequence

    sequence s_auto_cause_running;
        switching_en_o && cmp_r.auto_cause && !cmp_r.latch_cause &&
        !cmp_r.cond_cause && !mains_lost;
    endsequence

    AST_AUTO_TRIP: assert property (
        s_auto_cause_running |=> fault_auto_o && !switching_en_o)
        else $error("auto fault did not stop switching");
    AST_HICCUP_END: assert property (
        s_last_hiccup |=> switching_en_o && rst_cnt_r == '0)
        else $error("sixth supply cycle did not restart");
    AST_HICCUP_HOLD: assert property (
        fault_auto_o && !cycle_evt && !mains_lost |=>
        fault_auto_o && rst_cnt_r == $past(rst_cnt_r))
        else $error("auto fault left without supply cycle");
    AST_LATCH_HOLD: assert property (
        fault_latched_o && !mains_lost |=> fault_latched_o)
        else $error("latched fault released while mains present");
    AST_MAINS_CLEAR: assert property (
        mains_lost |=> state_r == pfrm_pkg::ST_WAIT_BROWN_IN &&
        !switching_en_o && rst_cnt_r == '0)
        else $error("mains loss did not clear faults");
    AST_SSTO: assert property (
        state_r == pfrm_pkg::ST_SOFT_START && ssto && !mains_lost &&
        !cmp_r.latch_cause && !cmp_r.cond_cause |=> fault_auto_o)
        else $error("soft-start timeout not handled");
    AST_OV_WINDOW: assert property (
        (state_r != pfrm_pkg::ST_SOFT_START || !cmp_r.high_side_on) |=>
        ov_cnt_r == '0)
        else $error("overvoltage filter ran outside its window");
    AST_OV_FILTER: assert property (
        ov_trip |-> $past(ov_act) && $past(ov_cnt_r) == OV_LIM - 1'b1)
        else $error("overvoltage tripped before filter time");
    AST_BROWN_IN: assert property (
        state_r == pfrm_pkg::ST_WAIT_BROWN_IN && !cmp_r.above_brown_in
        |=> !switching_en_o)
        else $error("conversion started without brown-in");
    AST_CLAMP_CUT: assert property (
        low_side_req_i && leb_cnt_r == LEB_LIM && cmp_r.over_clamp
        |=> !low_side_gate_cmd_o)
        else $error("gate not cut at current clamp");
    AST_COND_HOLD: assert property (
        state_r == pfrm_pkg::ST_COND_WAIT && cmp_r.cond_cause &&
        !mains_lost |=> state_r == pfrm_pkg::ST_COND_WAIT)
        else $error("conditioned fault left while cause present");
    AST_HV_PULSE: assert property (
        fault_latched_o && !cmp_r.supply_above_off && !mains_lost
        |=> hv_startup_en_o)
        else $error("startup generator not enabled in latch");
    AST_BO_FILTER: assert property (
        $rose(bo_trip) |-> $past(bo_cnt_r) == BO_LIM - 1'b1)
        else $error("brown-out tripped before deglitch time");
endmodule // pfrm_fault_manager

//--- verification/pfrm_far_side_model.sv
`timescale 1ns/1ps
// ========================================================
// Primary supply and secondary-side activity model
// ========================================================
module pfrm_far_side_model (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic hv_startup_en_i,
    input wire logic hold_up_i,
    input wire logic switching_en_i,
    input int sec_delay_i,
    output logic supply_above_off_o,
    output logic supply_at_on_o,
    output logic secondary_active_o
);
    int lvl;
    int cnt;

    // Supply charges from the startup path or aux winding, else decays
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lvl <= 45;
            cnt <= 0;
        end else begin
            if (hv_startup_en_i || hold_up_i) begin
                lvl <= (lvl < 45) ? lvl + 1 : 45;
            end else begin
                lvl <= (lvl > 0) ? lvl - 1 : 0;
            end
            cnt <= switching_en_i ? cnt + 1 : 0;
        end
    end

    // Zero delay means a dead secondary that never answers
    assign secondary_active_o = (sec_delay_i > 0) && (cnt >= sec_delay_i);
    assign supply_above_off_o = lvl > 10;
    assign supply_at_on_o = lvl >= 40;
endmodule // pfrm_far_side_model

//--- verification/primary_fault_restart_manager_test.sv
`timescale 1ns/1ps
module primary_fault_restart_manager_test;
    logic mclk_i = 1'h0;
    logic rst_b_i = 1'h0;
    logic req = 1'h0;
    pfrm_pkg::pfrm_cmp_s cmp = '0;
    pfrm_pkg::pfrm_cmp_s cmp_dut;
    logic sw, gate, hv, fa, fl, fc, p_off, p_on, p_sec, p_on_q, hv_q;
    int sec_dly = 0;
    int fails = 0;
    int n_compared = 0;
    int n_rise = 0;
    int n_hv = 0;
    logic q[$];
    string nm[5] = '{"switching_en", "hv_startup_en", "fault_auto",
                     "fault_latched", "fault_cond"};

    always #2 mclk_i = ~mclk_i;

    // Supply and secondary bits come from the far-side model
    always_comb begin
        cmp_dut = cmp;
        cmp_dut.supply_above_off = p_off;
        cmp_dut.supply_at_on = p_on;
        cmp_dut.secondary_active = p_sec;
    end

    pfrm_fault_manager #(.BO_DG_CYC(20)) u_dut (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .cmp_i(cmp_dut),
        .low_side_req_i(req), .switching_en_o(sw),
        .low_side_gate_cmd_o(gate), .hv_startup_en_o(hv),
        .fault_auto_o(fa), .fault_latched_o(fl), .fault_cond_o(fc));

    pfrm_far_side_model u_far (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .hv_startup_en_i(hv),
        .hold_up_i(!(fa || fl || fc)), .switching_en_i(sw),
        .sec_delay_i(sec_dly), .supply_above_off_o(p_off),
        .supply_at_on_o(p_on), .secondary_active_o(p_sec));

    // Count supply rises and startup generator pulses
    always @(posedge mclk_i) begin
        p_on_q <= p_on;
        hv_q <= hv;
        if (p_on && !p_on_q) n_rise <= n_rise + 1;
        if (hv && !hv_q) n_hv <= n_hv + 1;
    end

    // ========================================================
    // Shared tasks
    // ========================================================
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    task automatic chk(input string s, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %b, seen %b", s, e, g);
        end
    endtask

    function automatic logic pick(input int i);
        case (i)
            0: return sw;
            1: return hv;
            2: return fa;
            3: return fl;
            default: return fc;
        endcase
    endfunction

    // Bounded wait, so a stuck output fails instead of hanging
    task automatic wait_o(input int i, input logic v, input int bound);
        int k;
        k = 0;
        while (pick(i) !== v && k < bound) begin
            step(1);
            k++;
        end
        chk(nm[i], v, pick(i));
    endtask

    // Pin change at one edge shows at the outputs three edges on
    task automatic lat(input int i, input logic v);
        step(2);
        chk(nm[i], !v, pick(i));
        step(1);
        chk(nm[i], v, pick(i));
    endtask

    task automatic print_verdict;
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Watchdog well beyond the expected run of about 6000 cycles
    initial begin
        #(4 * 40000);
        fails++;
        print_verdict();
    end

    // ========================================================
    // Scenarios
    // ========================================================
    initial begin
        int base, i, j;
        logic b;
        void'($urandom(52));
        repeat (4) @(posedge mclk_i);
        rst_b_i <= 1'h1;
        step(30);
        for (i = 0; i < 5; i++) chk(nm[i], 1'h0, pick(i));
        @(posedge mclk_i) cmp.above_brown_in <= 1'h1;
        lat(0, 1'h1);
        @(posedge mclk_i) cmp.soft_start_end <= 1'h1;
        lat(2, 1'h1);
        base = n_rise;
        @(posedge mclk_i) cmp.soft_start_end <= 1'h0;
        wait_o(0, 1'h1, 1500);
        chk("six_rises", 1'h1, (n_rise - base) == 6);
        for (j = 0; j < 2; j++) begin
            @(posedge mclk_i);
            {cmp.ov_current, cmp.ov_voltage} <= j ? 2'h2 : 2'h1;
            step(300);
            chk(nm[2], 1'h0, fa);
            @(posedge mclk_i) cmp.high_side_on <= 1'h1;
            repeat (250) @(posedge mclk_i);
            cmp.high_side_on <= 1'h0;
            step(10);
            chk(nm[2], 1'h0, fa);
            @(posedge mclk_i) cmp.high_side_on <= 1'h1;
            step(250);
            chk(nm[2], 1'h0, fa);
            wait_o(2, 1'h1, 10);
            @(posedge mclk_i) {cmp.ov_current, cmp.ov_voltage} <= 2'h0;
            cmp.high_side_on <= 1'h0;
            wait_o(0, 1'h1, 1500);
        end
        // overvoltage ignored once the secondary runs
        sec_dly = 5;
        step(20);
        @(posedge mclk_i) {cmp.ov_voltage, cmp.high_side_on} <= 2'h3;
        step(400);
        chk(nm[2], 1'h0, fa);
        @(posedge mclk_i) {cmp.ov_voltage, cmp.high_side_on} <= 2'h0;
        @(posedge mclk_i) cmp.auto_cause <= 1'h1;
        lat(2, 1'h1);
        base = n_rise;
        @(posedge mclk_i) cmp.auto_cause <= 1'h0;
        wait_o(0, 1'h1, 1500);
        chk("six_rises", 1'h1, (n_rise - base) == 6);
        // clamp cut after blanking, no fault
        @(posedge mclk_i) {cmp.over_clamp, req} <= 2'h3;
        step(1);
        chk("gate", 1'h1, gate);
        step(47);
        chk("gate", 1'h1, gate);
        step(6);
        chk("gate", 1'h0, gate);
        chk(nm[0], 1'h1, sw);
        chk(nm[2], 1'h0, fa);
        @(posedge mclk_i) {cmp.over_clamp, req} <= 2'h0;
        // Random requests against a one-edge queue model
        for (i = 0; i < 200; i++) begin
            @(posedge mclk_i);
            b = 1'($urandom % 2);
            req <= b;
            q.push_back(b);
            #1;
            if (q.size() > 1) chk("gate", q.pop_front(), gate);
        end
        // conditioned restart after cause gone and one cycle
        @(posedge mclk_i) {cmp.cond_cause, req} <= 2'h2;
        lat(4, 1'h1);
        step(400);
        chk(nm[0], 1'h0, sw);
        for (i = 0; i < 200 && p_on !== 1'h1; i++) step(1);
        @(posedge mclk_i) cmp.cond_cause <= 1'h0;
        // Let the rise counter settle before taking the base
        #1;
        base = n_rise;
        wait_o(0, 1'h1, 300);
        chk("one_rise", 1'h1, (n_rise - base) == 1);
        // latched fault cleared by brown-out, x-cap
        for (j = 0; j < 2; j++) begin
            @(posedge mclk_i) cmp.latch_cause <= 1'h1;
            lat(3, 1'h1);
            @(posedge mclk_i) cmp.latch_cause <= 1'h0;
            base = n_hv;
            step(600);
            chk(nm[3], 1'h1, fl);
            chk("hv_pulses", 1'h1, (n_hv - base) >= 5);
            @(posedge mclk_i) begin
                if (j == 0) {cmp.below_brown_out, cmp.above_brown_in} <= 2'h2;
                else cmp.xcap_discharge <= 1'h1;
            end
            if (j == 0) begin
                repeat (20) @(posedge mclk_i);
                cmp.below_brown_out <= 1'h0;
                step(10);
                chk(nm[3], 1'h1, fl);
                @(posedge mclk_i) cmp.below_brown_out <= 1'h1;
            end
            wait_o(3, 1'h0, 40);
            step(20);
            chk(nm[0], 1'h0, sw);
            @(posedge mclk_i) begin
                {cmp.below_brown_out, cmp.xcap_discharge} <= 2'h0;
                cmp.above_brown_in <= 1'h1;
            end
            wait_o(0, 1'h1, 20);
        end
        print_verdict();
    end
endmodule // primary_fault_restart_manager_test
